// ===== design/csi_clock_status.sv
// Clock status flags, interrupt enables and clock select with AHB-Lite access
`timescale 1ns/1ps
module csi_clock_status
   import csi_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        resetn_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // Analog and mode pins
   input  wire logic        pll_lock_i,
   input  wire logic        xtal_ok_i,
   input  wire logic        special_mode_i,
   // Same-domain events
   input  wire logic        tick_expired_i,
   input  wire logic        full_stop_entry_i,
   input  wire logic [4:0]  synth_post_divider_i,
   // Results
   output logic             irq_o,
   output logic      [7:0]  clock_select_o,
   output logic      [5:0]  synth_divisor_o
);

   // --------------------------------------------------------------
   // Declarations
   // --------------------------------------------------------------
   logic             pll_meta_reg;
   logic             pll_sync_reg;
   logic             xtal_meta_reg;
   logic             xtal_sync_reg;
   logic             mode_meta_reg;
   logic             mode_sync_reg;

   logic             lock_reg;
   logic             qual_reg;
   logic             qual_next;
   logic             lock_change;
   logic             qual_change;

   logic             dphase_reg;
   logic             dwrite_reg;
   logic             dvalid_reg;
   logic [IDX_W-1:0] didx_reg;
   logic [31:0]      hrdata_reg;
   logic             hreadyout_reg;
   logic             hresp_reg;
   logic             wr_en;
   logic [7:0]       wbyte;

   logic [7:0]       flags_reg;
   logic [7:0]       flags_next;
   logic [7:0]       flag_set;
   logic [7:0]       flag_clr;
   logic [7:0]       enable_reg;
   logic             protect_reg;
   logic             wd_written_reg;
   logic             sel0_rearm_reg;
   logic             sel0_rearm_next;
   logic [7:0]       clksel_reg;
   logic [7:0]       clksel_next;
   logic             irq_reg;
   logic [5:0]       divisor_reg;

   // --------------------------------------------------------------
   // Address decode
   // --------------------------------------------------------------
   function automatic logic addr_mapped(input logic [31:0] a);
      logic [IDX_W-1:0] i;
      i = a[ADDR_LSB +: IDX_W];
      addr_mapped = (a[31:ADDR_LSB+IDX_W] == '0) &&
                    (a[ADDR_LSB-1:0] == '0) &&
                    (i >= IDX_FLAGS) && (i <= IDX_MODE);
   endfunction

   function automatic logic hit(input logic [IDX_W-1:0] i,
                                input logic [IDX_W-1:0] want);
      hit = (i == want);
   endfunction

   // --------------------------------------------------------------
   // Pin synchronisers
   // --------------------------------------------------------------
   // Lock pin
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pll_meta_reg <= 1'b0;
         pll_sync_reg <= 1'b0;
      end else begin
         pll_meta_reg <= pll_lock_i;
         pll_sync_reg <= pll_meta_reg;
      end
   end

   // Crystal qualified pin
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         xtal_meta_reg <= 1'b0;
         xtal_sync_reg <= 1'b0;
      end else begin
         xtal_meta_reg <= xtal_ok_i;
         xtal_sync_reg <= xtal_meta_reg;
      end
   end

   // Operating mode pin
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mode_meta_reg <= 1'b0;
         mode_sync_reg <= 1'b0;
      end else begin
         mode_meta_reg <= special_mode_i;
         mode_sync_reg <= mode_meta_reg;
      end
   end

   // --------------------------------------------------------------
   // Lock and crystal status
   // --------------------------------------------------------------
   assign qual_next   = xtal_sync_reg & ~full_stop_entry_i;
   assign lock_change = (pll_sync_reg != lock_reg);
   assign qual_change = (qual_next != qual_reg);

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lock_reg <= 1'b0;
      end else begin
         lock_reg <= pll_sync_reg;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         qual_reg <= 1'b0;
      end else begin
         qual_reg <= qual_next;
      end
   end

   // Divisor of the synthesizer output
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         divisor_reg <= RST_DIVISOR;
      end else if (lock_reg) begin
         divisor_reg <= {1'b0, synth_post_divider_i} + 6'h01;
      end else begin
         divisor_reg <= UNLOCKED_DIVISOR;
      end
   end

   // --------------------------------------------------------------
   // AHB-Lite slave, one wait state per transfer
   // --------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dphase_reg    <= 1'b0;
         dwrite_reg    <= 1'b0;
         dvalid_reg    <= 1'b0;
         didx_reg      <= '0;
         hreadyout_reg <= 1'b1;
      end else if (dphase_reg) begin
         dphase_reg    <= 1'b0;
         hreadyout_reg <= 1'b1;
      end else if (hsel_i && hready_i && htrans_i == HTRANS_NONSEQ) begin
         dphase_reg    <= 1'b1;
         dwrite_reg    <= hwrite_i;
         dvalid_reg    <= addr_mapped(haddr_i);
         didx_reg      <= haddr_i[ADDR_LSB +: IDX_W];
         hreadyout_reg <= 1'b0;
      end
   end

   assign wr_en = dphase_reg & dwrite_reg & dvalid_reg;
   assign wbyte = hwdata_i[7:0];

   // Response is always OKAY
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hresp_reg <= HRESP_OKAY;
      end else begin
         hresp_reg <= HRESP_OKAY;
      end
   end

   // Read data captured during the wait state
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hrdata_reg <= RDATA_ZERO;
      end else if (dphase_reg && !dwrite_reg && dvalid_reg) begin
         unique case (didx_reg)
            IDX_FLAGS: begin
               hrdata_reg <= {24'h0, (flags_reg & FLAG_MASK) |
                  (8'(lock_reg) << BIT_PLL_LOCK) |
                  (8'(qual_reg) << BIT_XTAL_QUAL)};
            end
            IDX_ENABLE: begin
               hrdata_reg <= {24'h0, enable_reg};
            end
            IDX_CLKSEL: begin
               hrdata_reg <= {24'h0, clksel_reg};
            end
            IDX_PROTECT: begin
               hrdata_reg <= {31'h0, protect_reg};
            end
            IDX_WDCTL: begin
               hrdata_reg <= {31'h0, wd_written_reg};
            end
            IDX_MODE: begin
               hrdata_reg <= {31'h0, mode_sync_reg};
            end
            default: begin
               hrdata_reg <= RDATA_ZERO;
            end
         endcase
      end else if (dphase_reg) begin
         hrdata_reg <= RDATA_ZERO;
      end
   end

   // --------------------------------------------------------------
   // Interrupt flags
   // --------------------------------------------------------------
   always_comb begin
      flag_set = 8'h00;
      flag_set[BIT_TICK_FLAG] = tick_expired_i;
      flag_set[BIT_PLL_FLAG]  = lock_change;
      flag_set[BIT_XTAL_FLAG] = qual_change;
      flag_clr = (wr_en && hit(didx_reg, IDX_FLAGS)) ?
                 wbyte : 8'h00;
      flags_next = (flag_set | (flags_reg & ~flag_clr)) &
                   FLAG_MASK;
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         flags_reg <= RST_FLAGS;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // Enable register
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         enable_reg <= RST_ENABLE;
      end else if (wr_en && hit(didx_reg, IDX_ENABLE)) begin
         enable_reg <= wbyte & ENABLE_MASK;
      end
   end

   // Level request while any enabled flag is set
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(flags_next & enable_reg);
      end
   end

   // --------------------------------------------------------------
   // Protection and watchdog control write tracking
   // --------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         protect_reg <= RST_PROTECT;
      end else if (wr_en && hit(didx_reg, IDX_PROTECT)) begin
         protect_reg <= wbyte[0];
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wd_written_reg <= 1'b0;
      end else if (wr_en && hit(didx_reg, IDX_WDCTL)) begin
         wd_written_reg <= 1'b1;
      end
   end

   // --------------------------------------------------------------
   // Clock select register
   // --------------------------------------------------------------
   always_comb begin
      clksel_next     = clksel_reg;
      sel0_rearm_next = sel0_rearm_reg;
      if (wr_en && hit(didx_reg, IDX_CLKSEL) && !protect_reg) begin
         if (mode_sync_reg) begin
            clksel_next = wbyte;
         end else begin
            clksel_next[BIT_SYS_FROM_SYNTH]  = wbyte[BIT_SYS_FROM_SYNTH];
            clksel_next[BIT_KEEP_XTAL_STOP]  = wbyte[BIT_KEEP_XTAL_STOP];
            clksel_next[BIT_TICK_LIGHT_STOP] = wbyte[BIT_TICK_LIGHT_STOP];
            clksel_next[BIT_WD_LIGHT_STOP]   = wbyte[BIT_WD_LIGHT_STOP];
            clksel_next[BIT_TICK_CLK_SRC]    = wbyte[BIT_TICK_CLK_SRC];
            if (!wd_written_reg) begin
               clksel_next[BIT_WD_STOP_CLK_DIS] =
                  wbyte[BIT_WD_STOP_CLK_DIS];
               clksel_next[BIT_WD_CLK_SEL_1] =
                  wbyte[BIT_WD_CLK_SEL_1];
               clksel_next[BIT_WD_CLK_SEL_0] =
                  wbyte[BIT_WD_CLK_SEL_0];
            end else if (sel0_rearm_reg && wbyte[BIT_WD_CLK_SEL_0]) begin
               clksel_next[BIT_WD_CLK_SEL_0] = 1'b1;
               sel0_rearm_next = 1'b0;
            end
         end
         if (!wbyte[BIT_SYS_FROM_SYNTH] && !qual_reg) begin
            clksel_next[BIT_SYS_FROM_SYNTH] = 1'b1;
         end
      end
      // Loss of qualification, select 1 left alone
      if (!qual_next) begin
         clksel_next[BIT_SYS_FROM_SYNTH] = 1'b1;
         if (clksel_reg[BIT_WD_CLK_SEL_0]) begin
            sel0_rearm_next = 1'b1;
         end
         clksel_next[BIT_WD_CLK_SEL_0] = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         clksel_reg <= RST_CLKSEL;
      end else begin
         clksel_reg <= clksel_next;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel0_rearm_reg <= 1'b0;
      end else begin
         sel0_rearm_reg <= sel0_rearm_next;
      end
   end

   // --------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------
   assign hrdata_o        = hrdata_reg;
   assign hreadyout_o     = hreadyout_reg;
   assign hresp_o         = hresp_reg;
   assign irq_o           = irq_reg;
   assign clock_select_o  = clksel_reg;
   assign synth_divisor_o = divisor_reg;

endmodule

// ===== design/csi_pkg.sv
// Constants for the clock status, interrupt and clock select block
package csi_pkg;

   // --------------------------------------------------------------
   // Register indices and byte addresses
   // --------------------------------------------------------------
   localparam logic [7:0] IDX_FLAGS   = 8'h07;
   localparam logic [7:0] IDX_ENABLE  = 8'h08;
   localparam logic [7:0] IDX_CLKSEL  = 8'h09;
   localparam logic [7:0] IDX_PROTECT = 8'h0a;
   localparam logic [7:0] IDX_WDCTL   = 8'h0b;
   localparam logic [7:0] IDX_MODE    = 8'h0c;
   localparam int         ADDR_LSB    = 2;
   localparam int         IDX_W       = 8;

   // --------------------------------------------------------------
   // Flag and enable register fields
   // --------------------------------------------------------------
   localparam int BIT_TICK_FLAG  = 7;
   localparam int BIT_PLL_FLAG   = 4;
   localparam int BIT_PLL_LOCK   = 3;
   localparam int BIT_XTAL_FLAG  = 1;
   localparam int BIT_XTAL_QUAL  = 0;
   localparam logic [7:0] FLAG_MASK   = 8'h92;
   localparam logic [7:0] ENABLE_MASK = 8'h92;

   // --------------------------------------------------------------
   // Clock select register fields
   // --------------------------------------------------------------
   localparam int BIT_SYS_FROM_SYNTH = 7;
   localparam int BIT_KEEP_XTAL_STOP = 6;
   localparam int BIT_WD_STOP_CLK_DIS = 5;
   localparam int BIT_WD_CLK_SEL_1   = 4;
   localparam int BIT_TICK_LIGHT_STOP = 3;
   localparam int BIT_WD_LIGHT_STOP  = 2;
   localparam int BIT_TICK_CLK_SRC   = 1;
   localparam int BIT_WD_CLK_SEL_0   = 0;

   // --------------------------------------------------------------
   // Reset values
   // --------------------------------------------------------------
   localparam logic [7:0] RST_FLAGS   = 8'h00;
   localparam logic [7:0] RST_ENABLE  = 8'h00;
   localparam logic [7:0] RST_CLKSEL  = 8'h80;
   localparam logic       RST_PROTECT = 1'b0;
   localparam logic [5:0] RST_DIVISOR = 6'h04;

   // --------------------------------------------------------------
   // Synthesizer divisor while unlocked
   // --------------------------------------------------------------
   localparam logic [5:0] UNLOCKED_DIVISOR = 6'h04;

   // --------------------------------------------------------------
   // Bus encodings
   // --------------------------------------------------------------
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic        HRESP_OKAY    = 1'b0;
   localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

endpackage

// ===== dv/csi_clock_status_sva.sv
// Assertion checker for the clock status block
`timescale 1ns/1ps
module csi_clock_status_sva
   import csi_pkg::*;
(
   input wire logic        core_clk_i,
   input wire logic        resetn_i,
   input wire logic        hsel_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic        hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   input wire logic        pll_lock_i,
   input wire logic        xtal_ok_i,
   input wire logic        full_stop_entry_i,
   input wire logic        tick_expired_i,
   input wire logic [4:0]  synth_post_divider_i,
   input wire logic        irq_o,
   input wire logic [7:0]  clock_select_o,
   input wire logic [5:0]  synth_divisor_o
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   logic acc;
   logic wr_acc;
   assign acc = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ;
   assign wr_acc = acc && hwrite_i;
   property p_ready_wait;
      acc |=> !hreadyout_o ##1 hreadyout_o;
   endproperty
   property p_resp_okay;
      hreadyout_o |-> hresp_o == HRESP_OKAY;
   endproperty
   property p_rdata_hi;
      hreadyout_o |-> hrdata_o[31:8] == 24'h0;
   endproperty
   property p_div_locked;
      (pll_lock_i && $stable(synth_post_divider_i))[*5]
         |=> synth_divisor_o ==
             6'({1'b0, $past(synth_post_divider_i)} + 6'h01);
   endproperty
   property p_div_unlocked;
      (!pll_lock_i)[*5] |=> synth_divisor_o == UNLOCKED_DIVISOR;
   endproperty
   property p_unqual_synth;
      (!xtal_ok_i)[*5] |=> clock_select_o[BIT_SYS_FROM_SYNTH];
   endproperty
   property p_stop_synth;
      full_stop_entry_i[*3] |=> clock_select_o[BIT_SYS_FROM_SYNTH];
   endproperty
   property p_sel1_kept;
      $fell(clock_select_o[BIT_WD_CLK_SEL_1]) |-> $past(wr_acc, 2);
   endproperty
   property p_synth_fell;
      $fell(clock_select_o[BIT_SYS_FROM_SYNTH]) |-> $past(wr_acc, 2);
   endproperty
   property p_irq_fell;
      $fell(irq_o) |-> $past(wr_acc, 2) || $past(wr_acc, 3);
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("wait state");
   a_resp_okay: assert property (p_resp_okay) else $error("bad response");
   a_rdata_hi: assert property (p_rdata_hi) else $error("upper bits");
   a_div_locked: assert property (p_div_locked) else $error("div lock");
   a_div_unlocked: assert property (p_div_unlocked) else $error("div");
   a_unqual_synth: assert property (p_unqual_synth) else $error("sel");
   a_stop_synth: assert property (p_stop_synth) else $error("stop");
   a_sel1_kept: assert property (p_sel1_kept) else $error("sel1");
   a_synth_fell: assert property (p_synth_fell) else $error("syn");
   a_irq_fell: assert property (p_irq_fell) else $error("irq drop");
   c_tick: cover property (tick_expired_i ##1 irq_o);
   c_stop: cover property (full_stop_entry_i[*3]);
   c_write: cover property (wr_acc);
endmodule

bind csi_clock_status csi_clock_status_sva csi_clock_status_sva_i (
   .core_clk_i(core_clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
   .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
   .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .pll_lock_i(pll_lock_i), .xtal_ok_i(xtal_ok_i),
   .full_stop_entry_i(full_stop_entry_i), .tick_expired_i(tick_expired_i),
   .synth_post_divider_i(synth_post_divider_i), .irq_o(irq_o),
   .clock_select_o(clock_select_o), .synth_divisor_o(synth_divisor_o));

// ===== dv/csi_clock_status_test.sv
// Self-checking bench for the clock status block
`timescale 1ns/1ps
module csi_clock_status_test
   import csi_pkg::*;
;
   logic        core_clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        hsel_i = 1'b0;
   logic        hwrite_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [31:0] hwdata_i = 32'h0;
   logic [1:0]  htrans_i = 2'h0;
   logic        pll_lock_i = 1'b0;
   logic        xtal_ok_i = 1'b0;
   logic        special_mode_i = 1'b0;
   logic        tick_expired_i = 1'b0;
   logic        full_stop_entry_i = 1'b0;
   logic [4:0]  synth_post_divider_i = 5'h00;
   logic [31:0] hrdata_o;
   logic        hreadyout_o;
   logic        hresp_o;
   logic        irq_o;
   logic [7:0]  clock_select_o;
   logic [5:0]  synth_divisor_o;
   int          n_mismatch = 0;
   int          check_count = 0;

   always #2 core_clk_i = ~core_clk_i;

   csi_clock_status csi_clock_status_i (
      .core_clk_i(core_clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
      .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
      .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .pll_lock_i(pll_lock_i), .xtal_ok_i(xtal_ok_i),
      .special_mode_i(special_mode_i), .tick_expired_i(tick_expired_i),
      .full_stop_entry_i(full_stop_entry_i),
      .synth_post_divider_i(synth_post_divider_i), .irq_o(irq_o),
      .clock_select_o(clock_select_o), .synth_divisor_o(synth_divisor_o));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic give_verdict();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (hreadyout_o !== 1'b1 && n < 20);
      if (hreadyout_o !== 1'b1) begin
         n_mismatch++;
         give_verdict();
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rdata);
      hsel_i <= 1'b1;
      haddr_i <= {22'h0, idx, 2'b00};
      htrans_i <= HTRANS_NONSEQ;
      hwrite_i <= w;
      wait_ready();
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      wait_ready();
      rdata = hrdata_o;
      check({31'h0, hresp_o}, {31'h0, HRESP_OKAY});
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] v;
      xfer(1'b1, idx, {24'h0, d}, v);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] v;
      xfer(1'b0, idx, 32'h0, v);
      check(v, {24'h0, exp});
   endtask
   task automatic settle();
      repeat (5) @(posedge core_clk_i);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      @(posedge core_clk_i);
      rd(IDX_FLAGS, 8'h00);
      rd(IDX_ENABLE, 8'h00);
      rd(IDX_CLKSEL, 8'h80);
      rd(8'h40, 8'h00);
      check({26'h0, synth_divisor_o}, 32'h4);
      wr(IDX_ENABLE, 8'hff);
      rd(IDX_ENABLE, 8'h92);
      tick_expired_i <= 1'b1;
      @(posedge core_clk_i);
      tick_expired_i <= 1'b0;
      @(posedge core_clk_i);
      check({31'h0, irq_o}, 32'h1);
      rd(IDX_FLAGS, 8'h80);
      wr(IDX_FLAGS, 8'h00);
      rd(IDX_FLAGS, 8'h80);
      wr(IDX_ENABLE, 8'h12);
      settle();
      check({31'h0, irq_o}, 32'h0);
      wr(IDX_FLAGS, 8'h80);
      rd(IDX_FLAGS, 8'h00);
      pll_lock_i <= 1'b1;
      synth_post_divider_i <= 5'h05;
      settle();
      rd(IDX_FLAGS, 8'h18);
      check({31'h0, irq_o}, 32'h1);
      check({26'h0, synth_divisor_o}, 32'h6);
      wr(IDX_FLAGS, 8'h10);
      rd(IDX_FLAGS, 8'h08);
      xtal_ok_i <= 1'b1;
      settle();
      rd(IDX_FLAGS, 8'h0b);
      wr(IDX_FLAGS, 8'h02);
      rd(IDX_FLAGS, 8'h09);
      check({31'h0, irq_o}, 32'h0);
      wr(IDX_PROTECT, 8'h01);
      rd(IDX_PROTECT, 8'h01);
      wr(IDX_CLKSEL, 8'h7f);
      rd(IDX_CLKSEL, 8'h80);
      wr(IDX_PROTECT, 8'h00);
      wr(IDX_CLKSEL, 8'h7f);
      rd(IDX_CLKSEL, 8'h7f);
      wr(IDX_WDCTL, 8'h01);
      rd(IDX_WDCTL, 8'h01);
      wr(IDX_CLKSEL, 8'h80);
      rd(IDX_CLKSEL, 8'hb1);
      full_stop_entry_i <= 1'b1;
      settle();
      rd(IDX_CLKSEL, 8'hb0);
      rd(IDX_FLAGS, 8'h0a);
      full_stop_entry_i <= 1'b0;
      settle();
      wr(IDX_CLKSEL, 8'h31);
      rd(IDX_CLKSEL, 8'h31);
      special_mode_i <= 1'b1;
      settle();
      rd(IDX_MODE, 8'h01);
      wr(IDX_CLKSEL, 8'h40);
      rd(IDX_CLKSEL, 8'h40);
      check({24'h0, clock_select_o}, 32'h40);
      full_stop_entry_i <= 1'b1;
      settle();
      wr(IDX_CLKSEL, 8'h00);
      rd(IDX_CLKSEL, 8'h80);
      // Reset in mid-run
      resetn_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      check({31'h0, irq_o}, 32'h0);
      check({26'h0, synth_divisor_o}, 32'h4);
      resetn_i <= 1'b1;
      settle();
      check({24'h0, clock_select_o}, 32'h80);
      rd(IDX_ENABLE, 8'h00);
      rd(IDX_FLAGS, 8'h18);
      rd(IDX_WDCTL, 8'h00);
      check({31'h0, irq_o}, 32'h0);
      give_verdict();
   end
endmodule
